//--- logic/kmw_params.svh
// Register offsets, reset values, field positions and timing counts of the wake detector.
`ifndef KMW_PARAMS_SVH
`define KMW_PARAMS_SVH

// Register indices; the byte address is four times the index, plus the bank base.
`define KMW_IDX_WAKE_CONFIG  6'h13
`define KMW_IDX_WAKE_STATUS  6'h14
`define KMW_IDX_KBD_SHIFT    6'h16
`define KMW_IDX_MOUSE_SHIFT  6'h17
`define KMW_IDX_KEY_FIRST    6'h18
`define KMW_IDX_KEY_LAST     6'h1F
`define KMW_IDX_GP_NOMAIN    6'h1A
`define KMW_IDX_MISC_PB      6'h1B
`define KMW_IDX_GP_PB        6'h1C
// Address bit that selects the second register bank.
`define KMW_BANK_BIT         8

// Reset values.
`define KMW_RST_GP_NOMAIN    8'hFF
`define KMW_RST_MISC_PB      8'h00
`define KMW_RST_GP_PB        8'h00
`define KMW_RST_WAKE_CONFIG  8'h00
`define KMW_RST_KEY          8'h00

// Field positions of the wake configuration, misc routing and status registers.
`define KMW_KCFG_MSB         3
`define KMW_KCFG_LSB         0
`define KMW_MCFG_MSB         6
`define KMW_MCFG_LSB         4
`define KMW_PAR_DIS_BIT      7
`define KMW_MISC_USED_MSB    4
`define KMW_STAT_KBD_BIT     0
`define KMW_STAT_MOUSE_BIT   1

// Keyboard codes, configuration offsets and the mouse sync bit.
`define KMW_PWD_OFFSET       4'h7
`define KMW_RAW_OFFSET       4'h1
`define KMW_CODE_BREAK       8'hF0
`define KMW_CODE_EXTEND      8'hE0
`define KMW_MOUSE_SYNC_BIT   3

// Timing.
`define KMW_CLK_MHZ          100
`define KMW_IDLE_US          100
`define KMW_IDLE_CYC         (`KMW_IDLE_US * `KMW_CLK_MHZ)
`define KMW_DBL_MS           500
`define KMW_DBL_CYC          (`KMW_DBL_MS * 1000 * `KMW_CLK_MHZ)

`endif

//--- logic/kmw_pkg.sv
// Types shared by the keyboard and mouse wake detector.
package kmw_pkg;

  // Receiver states, one-hot.
  typedef enum logic [2:0] {
    KMW_RX_IDLE = 3'b001,
    KMW_RX_DATA = 3'b010,
    KMW_RX_STOP = 3'b100
  } kmw_rx_state_t;

  // Mouse wake behaviours.
  typedef enum logic [2:0] {
    KMW_M_OFF       = 3'b000,
    KMW_M_ANY       = 3'b001,
    KMW_M_LEFT      = 3'b010,
    KMW_M_LEFT_DBL  = 3'b011,
    KMW_M_RIGHT     = 3'b100,
    KMW_M_RIGHT_DBL = 3'b101,
    KMW_M_ANY_DBL_A = 3'b110,
    KMW_M_ANY_DBL_B = 3'b111
  } kmw_mouse_mode_t;

  // A received byte with its strobe.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } kmw_byte_t;

  // Raw events routed to the power-button pulse generator.
  typedef struct packed {
    logic cir;
    logic mouse;
    logic keyboard_event;
    logic ring2;
    logic ring1;
  } kmw_raw_ev_t;

endpackage

//--- logic/kmw_ps2_rx.sv
// Snooping receiver for one serial keyboard or mouse line.
`timescale 1ns/100ps
`include "kmw_params.svh"
module kmw_ps2_rx import kmw_pkg::*; #(
  parameter int IDLE_CYC = `KMW_IDLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_parity_dis,
  input  wire logic i_link_clk,
  input  wire logic i_link_data,
  output kmw_byte_t o_byte
);
  logic          clk_s1_r, clk_s2_r, clk_prev_r, dat_s1_r, dat_s2_r;
  logic          fall;
  kmw_rx_state_t state_r;
  logic [3:0]    cnt_r;
  logic [8:0]    sh_r;
  logic [13:0]   idle_r;

  // Two-stage synchronisers; only the second stage feeds logic.
  always_ff @(posedge i_clk) begin
    clk_s1_r   <= i_link_clk;
    clk_s2_r   <= clk_s1_r;
    clk_prev_r <= clk_s2_r;
    dat_s1_r   <= i_link_data;
    dat_s2_r   <= dat_s1_r;
  end

  // Data is valid at the falling edge of the link clock.
  assign fall = clk_prev_r & ~clk_s2_r;

  // Frame state machine: start, eight data bits, odd parity, stop.
  always_ff @(posedge i_clk) begin
    o_byte.valid <= 1'b0;
    if (i_rst || !i_enable) begin
      state_r     <= KMW_RX_IDLE;
      cnt_r       <= 4'h0;
      sh_r        <= 9'h000;
      idle_r      <= 14'h0000;
      o_byte.data <= 8'h00;
    end else begin
      idle_r <= fall ? 14'h0000 : idle_r + 14'h0001;
      case (state_r)
        KMW_RX_IDLE: begin
          if (fall && !dat_s2_r) begin
            state_r <= KMW_RX_DATA;
            cnt_r   <= 4'h0;
          end
        end
        KMW_RX_DATA: begin
          if (fall) begin
            sh_r  <= {dat_s2_r, sh_r[8:1]};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h8) begin
              state_r <= KMW_RX_STOP;
            end
          end
        end
        KMW_RX_STOP: begin
          if (fall) begin
            state_r <= KMW_RX_IDLE;
            if (dat_s2_r && ((^sh_r) || i_parity_dis)) begin
              o_byte.valid <= 1'b1;
              o_byte.data  <= sh_r[7:0];
            end
          end
        end
        default: state_r <= KMW_RX_IDLE;
      endcase
      // A frame that stalls is abandoned so the next start bit resynchronises.
      if (state_r != KMW_RX_IDLE && !fall && idle_r == 14'(IDLE_CYC - 1)) begin
        state_r <= KMW_RX_IDLE;
      end
    end
  end

  default clocking rx_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  rx_strobe_pulse_a: assert property (o_byte.valid |=> !o_byte.valid)
    else $error("received byte strobe longer than one cycle");
  rx_stall_drop_a: assert property ((state_r != KMW_RX_IDLE) && !fall
    && (idle_r == 14'(IDLE_CYC - 1)) && i_enable |=> state_r == KMW_RX_IDLE)
    else $error("stalled frame not abandoned");
endmodule

//--- logic/kmw_wake_top.sv
// Keyboard and mouse wake detection with wake event routing masks on APB.
//
// Contract
// - No-main-power mask resets to all ones.
// - Without main power, gate inputs by mask.
// - Route misc events to power button if enabled.
// - Route general inputs to power button if enabled.
// - Keyboard and mouse detectors work independently.
// - Detectors snoop lines, need no controller.
// - Any key, password, or raw sequence.
// - Zero key register matches any byte.
// - Password mode drops make and break prefixes.
// - Raw mode compares every received byte.
// - Mouse wakes on movement, clicks, double-clicks.
// - Mouse config decode, three-bit field.
// - Keyboard config zero disables detection.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "kmw_params.svh"
module kmw_wake_top import kmw_pkg::*; #(
  parameter int IDLE_CYC = `KMW_IDLE_CYC,
  parameter int DBL_CYC  = `KMW_DBL_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_main_power_ok,
  input  wire logic [7:0]  i_gp_event_in,
  input  wire logic        i_consumer_infrared_event,
  input  wire logic        i_ring_one_event,
  input  wire logic        i_ring_two_event,
  input  wire logic        i_kbd_link_clk,
  input  wire logic        i_kbd_link_data,
  input  wire logic        i_mouse_link_clk,
  input  wire logic        i_mouse_link_data,
  output logic      [7:0]  o_gp_event_detect,
  output logic      [7:0]  o_pwrbtn_gp,
  output kmw_raw_ev_t      o_pwrbtn_misc,
  output logic             o_keyboard_event,
  output logic             o_mouse_event
);
  logic [7:0]      gp_nomain_r, misc_pb_r, gp_pb_r, wake_config_r;
  logic [7:0]      key_match_regs [0:7];
  logic [7:0]      kbd_shift_r, mouse_shift_r;
  logic [1:0]      status_r;
  logic [31:0]     prdata_r, rd_data;
  logic            err_r, rd_ok;
  logic [7:0]      gp_s1_r, gp_s2_r;
  logic [3:0]      misc_s1_r, misc_s2_r;
  logic            main_ok_s, cir_s, ring1_s, ring2_s;
  logic            setup, wr_en, bank2;
  logic [5:0]      idx;
  kmw_byte_t       kbyte, mbyte;
  logic [3:0]      kcfg, klen;
  logic            kbd_en, pwd_mode, skip_r, kdrop, khit, krestart, klast;
  logic [2:0]      pos_r;
  logic            kbd_evt_r;
  kmw_mouse_mode_t mmode;
  logic            m_en, pkt_done_r, moved_r, armed_r, mouse_evt_r;
  logic [1:0]      midx_r;
  logic [2:0]      btn_new_r, btn_prev_r, sel, press;
  logic [25:0]     dbl_tmr_r;
  kmw_raw_ev_t     raw_ev;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge i_clk) begin
    gp_s1_r   <= i_gp_event_in;
    gp_s2_r   <= gp_s1_r;
    misc_s1_r <= {i_main_power_ok, i_consumer_infrared_event, i_ring_two_event,
                  i_ring_one_event};
    misc_s2_r <= misc_s1_r;
  end
  assign {main_ok_s, cir_s, ring2_s, ring1_s} = misc_s2_r;

  // Address decode; the bus answers with no wait states.
  assign setup    = i_psel & ~i_penable;
  assign wr_en    = i_psel & i_penable & i_pwrite & ~err_r;
  assign bank2    = i_paddr[`KMW_BANK_BIT];
  assign idx      = i_paddr[7:2];
  assign o_pready = 1'b1;

  // Read multiplexer and map check for the word in setup.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (i_paddr[11:9] != 3'h0 || i_paddr[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (bank2) begin
      case (idx)
        `KMW_IDX_GP_NOMAIN: rd_data[7:0] = gp_nomain_r;
        `KMW_IDX_MISC_PB:   rd_data[7:0] = misc_pb_r;
        `KMW_IDX_GP_PB:     rd_data[7:0] = gp_pb_r;
        default:            rd_ok = 1'b0;
      endcase
    end else if (idx >= `KMW_IDX_KEY_FIRST && idx <= `KMW_IDX_KEY_LAST) begin
      rd_data[7:0] = key_match_regs[idx[2:0]];
    end else begin
      case (idx)
        `KMW_IDX_WAKE_CONFIG: rd_data[7:0] = wake_config_r;
        `KMW_IDX_WAKE_STATUS: rd_data[1:0] = status_r;
        `KMW_IDX_KBD_SHIFT:   rd_data[7:0] = kbd_shift_r;
        `KMW_IDX_MOUSE_SHIFT: rd_data[7:0] = mouse_shift_r;
        default:              rd_ok = 1'b0;
      endcase
    end
  end

  // Read data and error are captured in setup and presented in access.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else if (setup) begin
      prdata_r <= i_pwrite ? 32'h0000_0000 : rd_data;
      err_r    <= ~rd_ok;
    end
  end
  assign o_prdata  = prdata_r;
  assign o_pslverr = i_psel & i_penable & err_r;

  // Routing masks and wake configuration.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gp_nomain_r   <= `KMW_RST_GP_NOMAIN;
      misc_pb_r     <= `KMW_RST_MISC_PB;
      gp_pb_r       <= `KMW_RST_GP_PB;
      wake_config_r <= `KMW_RST_WAKE_CONFIG;
    end else if (wr_en) begin
      if (bank2 && idx == `KMW_IDX_GP_NOMAIN) gp_nomain_r <= i_pwdata[7:0];
      if (bank2 && idx == `KMW_IDX_MISC_PB) misc_pb_r <= {3'b000, i_pwdata[4:0]};
      if (bank2 && idx == `KMW_IDX_GP_PB) gp_pb_r <= i_pwdata[7:0];
      if (!bank2 && idx == `KMW_IDX_WAKE_CONFIG) wake_config_r <= i_pwdata[7:0];
    end
  end

  // Key match registers, one per sequence position.
  genvar gk;
  generate
    for (gk = 0; gk < 8; gk++) begin : g_key
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          key_match_regs[gk] <= `KMW_RST_KEY;
        end else if (wr_en && !bank2 && idx == (`KMW_IDX_KEY_FIRST + 6'(gk))) begin
          key_match_regs[gk] <= i_pwdata[7:0];
        end
      end
    end
  endgenerate

  // Wake status bits; a new wake event wins over a write-one clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_r <= 2'b00;
    end else begin
      status_r <= (status_r & ~((wr_en && !bank2 && idx == `KMW_IDX_WAKE_STATUS)
                  ? i_pwdata[1:0] : 2'b00)) | {mouse_evt_r, kbd_evt_r};
    end
  end

  // Independent snooping receivers for the two lines.
  kmw_ps2_rx #(.IDLE_CYC(IDLE_CYC)) u_kbd_rx (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_enable     (kbd_en),
    .i_parity_dis (wake_config_r[`KMW_PAR_DIS_BIT]),
    .i_link_clk   (i_kbd_link_clk),
    .i_link_data  (i_kbd_link_data),
    .o_byte       (kbyte)
  );
  kmw_ps2_rx #(.IDLE_CYC(IDLE_CYC)) u_mouse_rx (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_enable     (m_en),
    .i_parity_dis (wake_config_r[`KMW_PAR_DIS_BIT]),
    .i_link_clk   (i_mouse_link_clk),
    .i_link_data  (i_mouse_link_data),
    .o_byte       (mbyte)
  );

  // Keyboard mode and sequence length decode.
  assign kcfg     = wake_config_r[`KMW_KCFG_MSB:`KMW_KCFG_LSB];
  assign kbd_en   = kcfg != 4'h0;
  assign pwd_mode = kcfg[3];
  assign klen     = pwd_mode ? kcfg - `KMW_PWD_OFFSET : kcfg + `KMW_RAW_OFFSET;
  assign kdrop    = pwd_mode && (kbyte.data == `KMW_CODE_EXTEND
                    || kbyte.data == `KMW_CODE_BREAK || skip_r);
  assign khit     = key_match_regs[pos_r] == 8'h00
                    || key_match_regs[pos_r] == kbyte.data;
  assign krestart = key_match_regs[0] == 8'h00 || key_match_regs[0] == kbyte.data;
  assign klast    = ({1'b0, pos_r} + 4'h1) == klen;

  // Keyboard sequence matcher.
  always_ff @(posedge i_clk) begin
    kbd_evt_r <= 1'b0;
    if (i_rst || !kbd_en) begin
      pos_r  <= 3'h0;
      skip_r <= 1'b0;
    end else if (kbyte.valid) begin
      if (pwd_mode && kbyte.data == `KMW_CODE_BREAK) begin
        skip_r <= 1'b1;
      end else if (pwd_mode && skip_r && kbyte.data != `KMW_CODE_EXTEND) begin
        skip_r <= 1'b0;
      end
      if (!kdrop) begin
        if (khit && klast) begin
          kbd_evt_r <= 1'b1;
          pos_r     <= 3'h0;
        end else if (khit) begin
          pos_r <= pos_r + 3'h1;
        end else begin
          pos_r <= krestart ? 3'h1 : 3'h0;
        end
      end
    end
  end

  // Keyboard and mouse shift registers show the last byte while enabled.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      kbd_shift_r   <= 8'h00;
      mouse_shift_r <= 8'h00;
    end else begin
      if (kbyte.valid && kbd_en) kbd_shift_r <= kbyte.data;
      if (mbyte.valid && m_en) mouse_shift_r <= mbyte.data;
    end
  end

  // Mouse packet assembly: buttons, then two movement bytes.
  assign mmode = kmw_mouse_mode_t'(wake_config_r[`KMW_MCFG_MSB:`KMW_MCFG_LSB]);
  assign m_en  = mmode != KMW_M_OFF;
  always_ff @(posedge i_clk) begin
    pkt_done_r <= 1'b0;
    if (i_rst || !m_en) begin
      midx_r    <= 2'h0;
      btn_new_r <= 3'h0;
      moved_r   <= 1'b0;
    end else if (mbyte.valid) begin
      case (midx_r)
        2'h0: begin
          if (mbyte.data[`KMW_MOUSE_SYNC_BIT]) begin
            btn_new_r <= mbyte.data[2:0];
            moved_r   <= 1'b0;
            midx_r    <= 2'h1;
          end
        end
        2'h1: begin
          moved_r <= mbyte.data != 8'h00;
          midx_r  <= 2'h2;
        end
        default: begin
          moved_r    <= moved_r | (mbyte.data != 8'h00);
          pkt_done_r <= 1'b1;
          midx_r     <= 2'h0;
        end
      endcase
    end
  end

  // Button selection per mouse mode.
  always_comb begin
    case (mmode)
      KMW_M_LEFT, KMW_M_LEFT_DBL:   sel = 3'b001;
      KMW_M_RIGHT, KMW_M_RIGHT_DBL: sel = 3'b010;
      KMW_M_OFF:                    sel = 3'b000;
      default:                      sel = 3'b111;
    endcase
  end
  assign press = btn_new_r & ~btn_prev_r & sel;

  // Mouse wake decision with the double-click window.
  always_ff @(posedge i_clk) begin
    mouse_evt_r <= 1'b0;
    if (i_rst || !m_en) begin
      btn_prev_r <= 3'h0;
      armed_r    <= 1'b0;
      dbl_tmr_r  <= 26'h0000000;
    end else begin
      if (armed_r) begin
        dbl_tmr_r <= dbl_tmr_r - 26'h0000001;
        if (dbl_tmr_r == 26'h0000001) armed_r <= 1'b0;
      end
      if (pkt_done_r) begin
        btn_prev_r <= btn_new_r;
        case (mmode)
          KMW_M_ANY: mouse_evt_r <= moved_r || (btn_new_r != 3'h0);
          KMW_M_LEFT, KMW_M_RIGHT: mouse_evt_r <= press != 3'h0;
          default: begin
            if (press != 3'h0 && armed_r) begin
              mouse_evt_r <= 1'b1;
              armed_r     <= 1'b0;
            end else if (press != 3'h0) begin
              armed_r   <= 1'b1;
              dbl_tmr_r <= 26'(DBL_CYC);
            end
          end
        endcase
      end
    end
  end

  // Routing of raw events to detectors and the power-button generator.
  assign raw_ev = '{cir: cir_s, mouse: mouse_evt_r, keyboard_event: kbd_evt_r,
                    ring2: ring2_s, ring1: ring1_s};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_gp_event_detect <= 8'h00;
      o_pwrbtn_gp       <= 8'h00;
      o_pwrbtn_misc     <= '0;
    end else begin
      o_gp_event_detect <= main_ok_s ? 8'h00 : (gp_s2_r & gp_nomain_r);
      o_pwrbtn_gp       <= gp_s2_r & gp_pb_r;
      o_pwrbtn_misc     <= raw_ev & misc_pb_r[`KMW_MISC_USED_MSB:0];
    end
  end
  assign o_keyboard_event = kbd_evt_r;
  assign o_mouse_event    = mouse_evt_r;

  default clocking top_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence kbd_final_hit;
    kbyte.valid && kbd_en && !kdrop && khit && klast;
  endsequence
  sequence dbl_second_press;
    pkt_done_r && armed_r && (press != 3'h0) && !(mmode inside {KMW_M_ANY, KMW_M_LEFT,
      KMW_M_RIGHT});
  endsequence

  nomain_reset_a: assert property ($past(i_rst) |-> gp_nomain_r == 8'hFF)
    else $error("no-main mask not all ones after reset");
  nomain_gate_a: assert property ((o_gp_event_detect & ~$past(gp_nomain_r)) == 8'h00
    && ($past(main_ok_s) -> o_gp_event_detect == 8'h00))
    else $error("event passed to detector while blocked");
  misc_route_a: assert property (misc_pb_r[7:5] == 3'b000
    && (o_pwrbtn_misc & ~$past(misc_pb_r[4:0])) == 5'h00)
    else $error("misc event routed while disabled");
  gp_pb_route_a: assert property (o_pwrbtn_gp == ($past(gp_s2_r) & $past(gp_pb_r)))
    else $error("general event routing to power button wrong");
  wildcard_adv_a: assert property (kbyte.valid && kbd_en && !kdrop && !klast
    && key_match_regs[pos_r] == 8'h00 |=> pos_r == $past(pos_r) + 3'h1)
    else $error("wildcard key did not advance matcher");
  prefix_drop_a: assert property (kbd_en && pwd_mode && kbyte.valid
    && kbyte.data == `KMW_CODE_EXTEND |=> pos_r == $past(pos_r) && !kbd_evt_r)
    else $error("prefix byte was compared in password mode");
  kbd_off_a: assert property (!kbd_en |=> !kbd_evt_r ##1 !kbd_evt_r || kbd_en)
    else $error("keyboard event while detection disabled");
  kbd_fire_a: assert property (kbd_final_hit |=> kbd_evt_r && pos_r == 3'h0)
    else $error("full match did not raise keyboard event");
  mouse_off_a: assert property (!m_en |=> !mouse_evt_r)
    else $error("mouse event while detection disabled");
  dbl_click_a: assert property (dbl_second_press |=> mouse_evt_r && !armed_r)
    else $error("double click not reported");
endmodule

//--- verif/kmw_link_model.sv
// Behavioural keyboard or mouse that sends framed bytes on its serial line.
`timescale 1ns/100ps
module kmw_link_model (
  output logic o_link_clk,
  output logic o_link_data
);
  // Both lines rest high on their pull-ups; the clock stands still between frames.
  initial begin
    o_link_clk = 1'b1;
    o_link_data = 1'b1;
  end

  // Sends start, eight data bits lowest first, odd parity and stop, 160 ns a bit.
  // A count below eleven cuts the frame short and leaves the clock standing high.
  task automatic send(input logic [7:0] b, input int n = 11);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    #1; // Keeps line changes clear of the bench's clock edges.
    for (int i = 0; i < n; i++) begin
      o_link_data = f[i];
      #40;
      o_link_clk = 1'b0;
      #80;
      o_link_clk = 1'b1;
      #40;
    end
    o_link_data = 1'b1; // Released line returns to its pull-up level.
    #399;
  endtask
endmodule

//--- verif/kmw_wake_top_test.sv
// Self-checking bench for the keyboard and mouse wake detector.
`timescale 1ns/100ps
module kmw_wake_top_test;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  q;
    logic        e;
  } kmw_row_t;

  logic        clk, rst, psel, pen, pwr, pready, pslverr, mpok, cir, r1, r2;
  logic        kclk, kdat, mclk, mdat, kev, mev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  gp, det, pbgp, kcnt, mcnt, pcnt;
  logic [4:0]  misc;
  int          num_errors = 0;
  int          n_compared = 0;
  kmw_row_t    rows [5] = '{'{12'h16C, 8'hFF, 8'h1F, 1'b0}, '{12'h170, 8'hA5, 8'hA5, 1'b0},
                            '{12'h168, 8'h3C, 8'h3C, 1'b0}, '{12'h058, 8'h77, 8'h00, 1'b0},
                            '{12'h300, 8'hFF, 8'h00, 1'b1}};
  logic [23:0] mrows [7] = '{24'h100908, 24'h200908, 24'h400A08, 24'h300909,
                             24'h500A0A, 24'h600C0C, 24'h700A0A};

  kmw_wake_top #(
    .IDLE_CYC (200),
    .DBL_CYC  (2000)
  ) uut (
    .i_clk                     (clk),
    .i_rst                     (rst),
    .i_psel                    (psel),
    .i_penable                 (pen),
    .i_pwrite                  (pwr),
    .i_paddr                   (paddr),
    .i_pwdata                  (pwdata),
    .o_prdata                  (prdata),
    .o_pready                  (pready),
    .o_pslverr                 (pslverr),
    .i_main_power_ok           (mpok),
    .i_gp_event_in             (gp),
    .i_consumer_infrared_event (cir),
    .i_ring_one_event          (r1),
    .i_ring_two_event          (r2),
    .i_kbd_link_clk            (kclk),
    .i_kbd_link_data           (kdat),
    .i_mouse_link_clk          (mclk),
    .i_mouse_link_data         (mdat),
    .o_gp_event_detect         (det),
    .o_pwrbtn_gp               (pbgp),
    .o_pwrbtn_misc             (misc),
    .o_keyboard_event          (kev),
    .o_mouse_event             (mev)
  );
  kmw_link_model kb (.o_link_clk(kclk), .o_link_data(kdat));
  kmw_link_model ms (.o_link_clk(mclk), .o_link_data(mdat));

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  // Counts one-cycle wake pulses, and those routed to the power button, so none is missed.
  always @(posedge clk) begin
    kcnt <= rst ? 8'h00 : kcnt + {7'h00, kev};
    mcnt <= rst ? 8'h00 : mcnt + {7'h00, mev};
    pcnt <= rst ? 8'h00 : pcnt + {7'h00, misc[2]} + {7'h00, misc[3]};
  end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound, then releases the bus.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] q);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, q);
    chk(e, 0);
  endtask

  // Clears the wake configuration before writing the new value.
  task automatic cfg(input logic [7:0] v);
    @(posedge clk);
    wr(12'h04C, 8'h00);
    wr(12'h04C, v);
  endtask

  task automatic keys(input logic [7:0] k0, input logic [7:0] k1, input logic [7:0] k2);
    wr(12'h060, k0);
    wr(12'h064, k1);
    wr(12'h068, k2);
  endtask

  task automatic pkt(input logic [7:0] b0, input logic [7:0] m);
    ms.send(b0);
    ms.send(m);
    ms.send(8'h00);
  endtask

  task automatic cnt(input logic [7:0] k, input logic [7:0] m);
    repeat (20) @(posedge clk);
    chk(kcnt, k);
    chk(mcnt, m);
  endtask

  // Guards against a hang anywhere in the run.
  initial begin
    #900us;
    num_errors++;
    end_of_test();
  end

  // Main sequence: reset, register rows, routing, keyboard and mouse wake.
  initial begin
    logic [31:0] r;
    logic        e;
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    mpok = 1'b1;
    gp = 8'h00;
    cir = 1'b0;
    r1 = 1'b0;
    r2 = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(12'h168, 32'hFF);
    rdc(12'h16C, 32'h00);
    rdc(12'h170, 32'h00);
    rdc(12'h04C, 32'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00, r, e);
      chk(r, rows[i].q);
      chk(e, rows[i].e);
    end
    gp <= 8'hFF;
    mpok <= 1'b0;
    cir <= 1'b1;
    r1 <= 1'b1;
    r2 <= 1'b1;
    repeat (6) @(posedge clk);
    chk(det, 8'h3C);
    chk(pbgp, 8'hA5);
    chk(misc, 5'h13);
    gp <= 8'h0F;
    cir <= 1'b0;
    r1 <= 1'b0;
    repeat (6) @(posedge clk);
    chk(det, 8'h0C);
    chk(pbgp, 8'h05);
    chk(misc, 5'h02);
    mpok <= 1'b1;
    repeat (6) @(posedge clk);
    chk(det, 8'h00);
    r1 <= 1'b1;
    wr(12'h16C, 8'h01);
    repeat (4) @(posedge clk);
    chk(misc, 5'h01);
    cfg(8'h01);
    kb.send(8'h1C);
    kb.send(8'hF0);
    cnt(8'd1, 8'd0);
    keys(8'h05, 8'h50, 8'h00);
    cfg(8'h09);
    kb.send(8'h50);
    kb.send(8'h05);
    kb.send(8'hF0);
    kb.send(8'h05);
    kb.send(8'hE0);
    kb.send(8'h50);
    cnt(8'd2, 8'd0);
    keys(8'hE0, 8'h5B, 8'hE0);
    cfg(8'h02);
    kb.send(8'hE0, 4);
    repeat (300) @(posedge clk);
    kb.send(8'hE0);
    kb.send(8'h5B);
    kb.send(8'hE0);
    cnt(8'd3, 8'd0);
    kb.send(8'hE0);
    kb.send(8'h5B);
    kb.send(8'h5B);
    kb.send(8'hE0);
    kb.send(8'h5B);
    kb.send(8'hE0);
    cnt(8'd4, 8'd0);
    cfg(8'h00);
    kb.send(8'hE0);
    kb.send(8'h5B);
    kb.send(8'hE0);
    cnt(8'd4, 8'd0);
    cfg(8'h10);
    pkt(8'h07, 8'h05);
    cnt(8'd4, 8'd0);
    pkt(8'h08, 8'h01);
    cnt(8'd4, 8'd1);
    foreach (mrows[i]) begin
      cfg(mrows[i][23:16]);
      pkt(8'h08, 8'h00);
      pkt(mrows[i][15:8], 8'h00);
      pkt(8'h08, 8'h00);
      pkt(mrows[i][7:0], 8'h00);
      cnt(8'd4, 8'd2 + i[7:0]);
    end
    keys(8'h00, 8'h00, 8'h00);
    wr(12'h16C, 8'h0C);
    cfg(8'h11);
    fork
      begin
        kb.send(8'h1C);
        kb.send(8'hF0);
      end
      pkt(8'h09, 8'h00);
    join
    cnt(8'd5, 8'd9);
    chk(pcnt, 8'd2);
    // A second reset in mid-run must restore the mask defaults.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(12'h168, 32'hFF);
    rdc(12'h16C, 32'h00);
    rdc(12'h170, 32'h00);
    chk(misc, 5'h00);
    chk(pbgp, 8'h00);
    end_of_test();
  end
endmodule
